/* File: hdl/lsdu_top.v */
`timescale 1ns/1ps
`include "lsdu_defs.vh"
// Contract
// - Break/sync loads baud, enables idle receiver, resets control, flags sync.
// - Sync strobe while receiving discards the partial byte silently.
// - Enabled idle receiver goes busy on a falling receive-line edge.
// - Data sampled at bit middles; receiver goes idle at stop-bit middle.
// - High stop stores byte if buffer empty, else drops it and flags overrun.
// - Low stop stores nothing and disables receiver until next sync.
// - After storing, receiver stays enabled and idle for further bytes.
// - Halt strobe clears enable and busy, resets control, self-clears.
// - A stopped receiver is re-enabled by the next sync strobe unless hard-disabled.
// - Hard-disable bit blocks re-enabling on sync detection.
// - Transmit buffer write clears receive flags and sets transmit busy.
// - Transmit-free clears on write, sets when byte moves to shifter.
// - Write to occupied buffer is dropped, sets collision, cleared by read.
// - Transmit high stop, low start, eight data bits, then release.
// - Continue if buffer holds a byte at byte end, else clear busy.
// - Bus conflicts stop transmit, empty buffer, set conflict flag.
// - Driven low but read high at bit end stops transmit, flags shutoff.
// - Sync strobe during transmit deactivates the transmitter.
// - After reset receiver not hard-disabled and idle timer disabled.
// - Sync strobe comes at stop-bit rising edge and updates baud.
// - Each byte is one low start, eight data, one high stop bit.
// - Enabled idle timer restarts on edges, interrupts after four seconds.
module lsdu_top (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output wire [7:0] reg_rdata_out,
	input wire sync_strobe_in,
	input wire [15:0] measured_baud_in,
	input wire idle_timeout_in,
	input wire rxd_in,
	output wire txd_out,
	output wire idle_timer_enable_out,
	output wire irq_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam TX_IDLE = 4'b0001;
	localparam TX_STOP = 4'b0010;
	localparam TX_START = 4'b0100;
	localparam TX_DATA = 4'b1000;

	reg [7:0] rdata_q;
	reg [15:0] baud_q;
	reg [7:0] irqen_q;
	reg rx_hard_disable_q;
	reg idle_timer_enable_q;
	reg rx_enabled_flag_q;
	reg rx_busy_flag_q;
	reg [15:0] rx_cnt_q;
	reg [3:0] rx_idx_q;
	reg [7:0] rx_shift_q;
	reg [7:0] rx_buf_q;
	reg rx_prev_q;
	reg sync_seen_flag_q;
	reg rx_buffer_loaded_flag_q;
	reg rx_overrun_flag_q;
	reg idle_flag_q;
	reg tx_busy_flag_q;
	reg tx_buffer_free_flag_q;
	reg [7:0] tx_buf_q;
	reg write_collision_flag_q;
	reg conflict_flag_q;
	reg phy_tx_shutoff_flag_q;
	reg [3:0] tx_state_q;
	reg [15:0] tx_cnt_q;
	reg [2:0] tx_idx_q;
	reg [7:0] tx_shift_q;
	reg txd_q;
	reg irq_q;

	wire wr_cfg;
	wire wr_stat;
	wire wr_data;
	wire rd_stat;
	wire rd_data;
	wire rx_fall;
	wire rx_tick;
	wire rx_stop_tick;
	wire rx_store;
	wire rx_lost;
	wire rx_bad_stop;
	wire halt;
	wire tx_start_ok;
	wire tx_coll;
	wire tx_load;
	wire tx_bit_end;
	wire tx_mid;
	wire tx_off_err;
	wire tx_conf_err;
	wire tx_abort;
	wire tx_byte_end;
	wire [7:0] cfg_vec;
	wire [7:0] stat_vec;

	// Half a bit time, used to place receive samples at bit middles.
	function [15:0] half_bit;
		input [15:0] b;
		begin
			half_bit = {1'b0, b[15:1]};
		end
	endfunction

	// Address match for a strobed access.
	function hit;
		input strobe;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = strobe && (a == off);
		end
	endfunction

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	// Strobed accesses, one per register and direction of interest.
	assign wr_cfg = hit(reg_wr_in, reg_addr_in, `LSDU_OFF_CFG);
	assign wr_stat = hit(reg_wr_in, reg_addr_in, `LSDU_OFF_STAT);
	assign wr_data = hit(reg_wr_in, reg_addr_in, `LSDU_OFF_DATA);
	assign rd_stat = hit(reg_rd_in, reg_addr_in, `LSDU_OFF_STAT);
	assign rd_data = hit(reg_rd_in, reg_addr_in, `LSDU_OFF_DATA);
	assign halt = wr_cfg && reg_wdata_in[`LSDU_CFG_HALT];

	assign cfg_vec = {2'b00, tx_busy_flag_q, rx_busy_flag_q,
		rx_enabled_flag_q, idle_timer_enable_q, rx_hard_disable_q, 1'b0};
	assign stat_vec = {idle_flag_q, phy_tx_shutoff_flag_q, conflict_flag_q,
		write_collision_flag_q, tx_buffer_free_flag_q, rx_overrun_flag_q,
		rx_buffer_loaded_flag_q, sync_seen_flag_q};

	// ----------------------------------------------------------------
	// Receive datapath decode
	// ----------------------------------------------------------------
	// A falling edge on the receive line starts a byte.
	assign rx_fall = rx_prev_q && !rxd_in;
	assign rx_tick = rx_busy_flag_q && (rx_cnt_q == 16'h0000);
	assign rx_stop_tick = rx_tick && (rx_idx_q == `LSDU_RX_STOP_IDX);
	assign rx_store = rx_stop_tick && rxd_in && !rx_buffer_loaded_flag_q;
	assign rx_lost = rx_stop_tick && rxd_in && rx_buffer_loaded_flag_q;
	assign rx_bad_stop = rx_stop_tick && !rxd_in;

	// ----------------------------------------------------------------
	// Transmit datapath decode
	// ----------------------------------------------------------------
	// A write is taken only into a free buffer; otherwise it collides.
	assign tx_start_ok = wr_data && tx_buffer_free_flag_q;
	assign tx_coll = wr_data && !tx_buffer_free_flag_q;
	assign tx_bit_end = !tx_state_q[0] && (tx_cnt_q == 16'h0000);
	assign tx_mid = tx_state_q[3] && (tx_cnt_q == half_bit(baud_q));
	assign tx_byte_end = tx_bit_end && tx_state_q[3] &&
		(tx_idx_q == `LSDU_TX_LAST_IDX);
	assign tx_load = !tx_buffer_free_flag_q && tx_busy_flag_q &&
		(tx_state_q[0] || tx_byte_end);
	// Driven low but read back high means the physical layer shut off.
	assign tx_off_err = tx_bit_end && !txd_q && rxd_in;
	// Recessive driven but dominant seen, or a write while receiving: another node is on the bus.
	assign tx_conf_err = (tx_state_q[1] && rx_fall) ||
		(tx_mid && txd_q && !rxd_in) ||
		(tx_start_ok && !tx_busy_flag_q && rx_busy_flag_q);
	assign tx_abort = tx_off_err || tx_conf_err;

	// ----------------------------------------------------------------
	// Configuration and baud registers
	// ----------------------------------------------------------------
	// Software settings; baud is also loaded by each sync strobe.
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			baud_q <= `LSDU_RST_BAUD;
			irqen_q <= `LSDU_RST_IRQEN;
			rx_hard_disable_q <= `LSDU_RST_HARDDIS;
			idle_timer_enable_q <= `LSDU_RST_TMREN;
		end else begin
			if (wr_cfg) begin
				rx_hard_disable_q <= reg_wdata_in[`LSDU_CFG_HARDDIS];
				idle_timer_enable_q <= reg_wdata_in[`LSDU_CFG_TMREN];
			end
			if (hit(reg_wr_in, reg_addr_in, `LSDU_OFF_IRQEN)) begin
				irqen_q <= reg_wdata_in;
			end
			if (sync_strobe_in) begin
				baud_q <= measured_baud_in;
			end else if (hit(reg_wr_in, reg_addr_in, `LSDU_OFF_BAUDHI)) begin
				baud_q <= {reg_wdata_in, baud_q[7:0]};
			end else if (hit(reg_wr_in, reg_addr_in, `LSDU_OFF_BAUDLO)) begin
				baud_q <= {baud_q[15:8], reg_wdata_in};
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive control
	// ----------------------------------------------------------------
	// Enable and busy flags, bit timer and shift register.
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_enabled_flag_q <= 1'b0;
			rx_busy_flag_q <= 1'b0;
			rx_cnt_q <= 16'h0000;
			rx_idx_q <= 4'h0;
			rx_shift_q <= 8'h00;
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= rxd_in;
			if (sync_strobe_in) begin
				// Partial byte is dropped without a flag.
				rx_enabled_flag_q <= !rx_hard_disable_q;
				rx_busy_flag_q <= 1'b0;
				rx_idx_q <= 4'h0;
			end else if (halt || tx_start_ok) begin
				rx_enabled_flag_q <= 1'b0;
				rx_busy_flag_q <= 1'b0;
				rx_idx_q <= 4'h0;
			end else if (rx_enabled_flag_q && !rx_busy_flag_q) begin
				if (rx_fall) begin
					rx_busy_flag_q <= 1'b1;
					rx_cnt_q <= half_bit(baud_q);
					rx_idx_q <= 4'h0;
				end
			end else if (rx_busy_flag_q) begin
				if (rx_tick) begin
					rx_cnt_q <= baud_q - 16'h0001;
					rx_idx_q <= rx_idx_q + 4'h1;
					if (rx_idx_q != 4'h0 && !rx_stop_tick) begin
						rx_shift_q <= {rxd_in, rx_shift_q[7:1]};
					end
					if (rx_stop_tick) begin
						rx_busy_flag_q <= 1'b0;
						rx_enabled_flag_q <= rxd_in;
					end
				end else begin
					rx_cnt_q <= rx_cnt_q - 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive buffer and receive status flags
	// ----------------------------------------------------------------
	// Hardware sets win over software clears.
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_buf_q <= 8'h00;
			rx_buffer_loaded_flag_q <= 1'b0;
			rx_overrun_flag_q <= 1'b0;
			sync_seen_flag_q <= 1'b0;
			idle_flag_q <= 1'b0;
		end else begin
			if (rx_store) begin
				rx_buf_q <= rx_shift_q;
				rx_buffer_loaded_flag_q <= 1'b1;
			end else if (rd_data) begin
				rx_buffer_loaded_flag_q <= 1'b0;
			end
			if (rx_lost) begin
				rx_overrun_flag_q <= 1'b1;
			end else if (rd_stat) begin
				rx_overrun_flag_q <= 1'b0;
			end
			if (sync_strobe_in) begin
				sync_seen_flag_q <= 1'b1;
			end else if (wr_stat && reg_wdata_in[`LSDU_ST_SYNC]) begin
				sync_seen_flag_q <= 1'b0;
			end
			if (idle_timeout_in && idle_timer_enable_q) begin
				idle_flag_q <= 1'b1;
			end else if (wr_stat && reg_wdata_in[`LSDU_ST_IDLE]) begin
				idle_flag_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit buffer and transmit status flags
	// ----------------------------------------------------------------
	// Buffer state, busy flag and error flags.
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_buf_q <= 8'h00;
			tx_buffer_free_flag_q <= 1'b1;
			tx_busy_flag_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			conflict_flag_q <= 1'b0;
			phy_tx_shutoff_flag_q <= 1'b0;
		end else begin
			if (tx_start_ok) begin
				tx_buf_q <= reg_wdata_in;
			end
			if (tx_abort) begin
				tx_buffer_free_flag_q <= 1'b1;
			end else if (tx_start_ok) begin
				tx_buffer_free_flag_q <= 1'b0;
			end else if (tx_load) begin
				tx_buffer_free_flag_q <= 1'b1;
			end
			if (tx_abort || sync_strobe_in) begin
				tx_busy_flag_q <= 1'b0;
			end else if (tx_start_ok) begin
				tx_busy_flag_q <= 1'b1;
			end else if (tx_byte_end && !tx_load) begin
				tx_busy_flag_q <= 1'b0;
			end
			if (tx_coll) begin
				write_collision_flag_q <= 1'b1;
			end else if (rd_stat) begin
				write_collision_flag_q <= 1'b0;
			end
			if (tx_conf_err) begin
				conflict_flag_q <= 1'b1;
			end else if (wr_stat && reg_wdata_in[`LSDU_ST_CONFL]) begin
				conflict_flag_q <= 1'b0;
			end
			if (tx_off_err) begin
				phy_tx_shutoff_flag_q <= 1'b1;
			end else if (wr_stat && reg_wdata_in[`LSDU_ST_PHY_TX_SHUTOFF_FLAG]) begin
				phy_tx_shutoff_flag_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit shifter
	// ----------------------------------------------------------------
	// Leading stop bit, start bit, eight data bits LSB first.
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_state_q <= TX_IDLE;
			tx_cnt_q <= 16'h0000;
			tx_idx_q <= 3'h0;
			tx_shift_q <= 8'h00;
			txd_q <= 1'b1;
		end else if (tx_abort || sync_strobe_in) begin
			tx_state_q <= TX_IDLE;
			txd_q <= 1'b1;
		end else if (tx_load) begin
			tx_state_q <= TX_STOP;
			tx_shift_q <= tx_buf_q;
			tx_cnt_q <= baud_q - 16'h0001;
			tx_idx_q <= 3'h0;
			txd_q <= 1'b1;
		end else if (!tx_bit_end) begin
			if (!tx_state_q[0]) begin
				tx_cnt_q <= tx_cnt_q - 16'h0001;
			end
		end else begin
			tx_cnt_q <= baud_q - 16'h0001;
			case (tx_state_q)
				TX_STOP: begin
					tx_state_q <= TX_START;
					txd_q <= 1'b0;
				end
				TX_START: begin
					tx_state_q <= TX_DATA;
					txd_q <= tx_shift_q[0];
				end
				TX_DATA: begin
					if (tx_idx_q == `LSDU_TX_LAST_IDX) begin
						tx_state_q <= TX_IDLE;
						txd_q <= 1'b1;
					end else begin
						tx_idx_q <= tx_idx_q + 3'h1;
						tx_shift_q <= {1'b0, tx_shift_q[7:1]};
						txd_q <= tx_shift_q[1];
					end
				end
				default: begin
					tx_state_q <= TX_IDLE;
					txd_q <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read data and interrupt request
	// ----------------------------------------------------------------
	// Read data stands one cycle after the read strobe; unmapped reads 0.
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_vec & irqen_q);
			if (reg_rd_in) begin
				case (reg_addr_in)
					`LSDU_OFF_CFG: rdata_q <= cfg_vec;
					`LSDU_OFF_STAT: rdata_q <= stat_vec;
					`LSDU_OFF_DATA: rdata_q <= rx_buf_q;
					`LSDU_OFF_IRQEN: rdata_q <= irqen_q;
					`LSDU_OFF_BAUDHI: rdata_q <= baud_q[15:8];
					`LSDU_OFF_BAUDLO: rdata_q <= baud_q[7:0];
					default: rdata_q <= 8'h00;
				endcase
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

	assign reg_rdata_out = rdata_q;
	assign txd_out = txd_q;
	assign idle_timer_enable_out = idle_timer_enable_q;
	assign irq_out = irq_q;

endmodule

/* File: hdl/lsdu_defs.vh */
`ifndef LSDU_DEFS_VH
`define LSDU_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define LSDU_ADDR_W 8
`define LSDU_OFF_CFG 8'h00
`define LSDU_OFF_STAT 8'h04
`define LSDU_OFF_DATA 8'h08
`define LSDU_OFF_IRQEN 8'h0c
`define LSDU_OFF_BAUDHI 8'h10
`define LSDU_OFF_BAUDLO 8'h14

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define LSDU_CFG_HALT 0
`define LSDU_CFG_HARDDIS 1
`define LSDU_CFG_TMREN 2
`define LSDU_CFG_RX_ENABLED_FLAG 3
`define LSDU_CFG_RXBUSY 4
`define LSDU_CFG_TXBUSY 5

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define LSDU_ST_SYNC 0
`define LSDU_ST_RX_BUFFER_LOADED_FLAG 1
`define LSDU_ST_OVR 2
`define LSDU_ST_TXFREE 3
`define LSDU_ST_WRITE_COLLISION_FLAG 4
`define LSDU_ST_CONFL 5
`define LSDU_ST_PHY_TX_SHUTOFF_FLAG 6
`define LSDU_ST_IDLE 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSDU_RST_BAUD 16'h0100
`define LSDU_RST_IRQEN 8'h00
`define LSDU_RST_HARDDIS 1'b0
`define LSDU_RST_TMREN 1'b0

// ----------------------------------------------------------------
// Frame layout: receive start bit at index 0, data 1..8, stop bit at 9; transmit data 0..7
// ----------------------------------------------------------------
`define LSDU_RX_STOP_IDX 4'h9
`define LSDU_TX_LAST_IDX 3'h7

`endif

/* File: dv/lsdu_checker_sva.sv */
`timescale 1ns/1ps
`include "lsdu_defs.vh"
// ----------------------------------------------------------------
// Port checker for the slave link unit
// ----------------------------------------------------------------
module lsdu_checker (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_rdata_out,
	input wire sync_strobe_in,
	input wire idle_timeout_in,
	input wire rxd_in,
	input wire txd_out,
	input wire idle_timer_enable_out,
	input wire irq_out
);
	logic hd_q;
	logic tm_q;
	logic [7:0] ie_q;
	// Shadow copies of the software-written control bits.
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hd_q <= 1'b0;
			tm_q <= 1'b0;
			ie_q <= 8'h00;
		end else if (reg_wr_in && reg_addr_in == `LSDU_OFF_CFG) begin
			hd_q <= reg_wdata_in[`LSDU_CFG_HARDDIS];
			tm_q <= reg_wdata_in[`LSDU_CFG_TMREN];
		end else if (reg_wr_in && reg_addr_in == `LSDU_OFF_IRQEN) begin
			ie_q <= reg_wdata_in;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data not zero outside a read");
	AST_UNMAPPED: assert property (reg_rd_in && reg_addr_in > 8'h14
		|=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	AST_HALT_READS_ZERO: assert property (
		reg_rd_in && reg_addr_in == `LSDU_OFF_CFG |=> !reg_rdata_out[0])
		else $error("halt strobe bit did not read zero");
	AST_HALT_CLEARS: assert property (
		reg_wr_in && reg_addr_in == `LSDU_OFF_CFG && reg_wdata_in[0]
		&& !sync_strobe_in ##1 (reg_rd_in && !sync_strobe_in
		&& reg_addr_in == `LSDU_OFF_CFG) |=> reg_rdata_out[4:3] == 2'b00)
		else $error("halt did not clear receive flags");
	AST_SYNC_FLAG: assert property (sync_strobe_in ##1
		(reg_rd_in && reg_addr_in == `LSDU_OFF_STAT) |=> reg_rdata_out[0])
		else $error("sync seen flag not set");
	AST_SYNC_RX_ENABLED_FLAG: assert property (sync_strobe_in && !hd_q ##1
		(reg_rd_in && reg_addr_in == `LSDU_OFF_CFG) |=> reg_rdata_out[3])
		else $error("receiver not enabled by sync");
	AST_TIMER_EN: assert property (idle_timer_enable_out == tm_q)
		else $error("idle timer enable differs from config");
	AST_IRQ_MASK: assert property (ie_q == 8'h00
		&& $past(ie_q) == 8'h00 |-> !irq_out)
		else $error("interrupt raised with all enables off");
	AST_TX_LOW_HOLD: assert property (
		$fell(txd_out) |-> !txd_out [*8])
		else $error("low bit shorter than expected");
	AST_TX_HIGH_HOLD: assert property (
		$rose(txd_out) |-> txd_out [*8])
		else $error("high bit shorter than expected");
	COV_SYNC: cover property (sync_strobe_in ##1 reg_rd_in);
	COV_TX: cover property ($fell(txd_out));
	COV_IRQ: cover property ($rose(irq_out));
endmodule
bind lsdu_top lsdu_checker u_chk (.ref_clk_in(ref_clk_in),
	.resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.sync_strobe_in(sync_strobe_in), .idle_timeout_in(idle_timeout_in),
	.rxd_in(rxd_in), .txd_out(txd_out), .irq_out(irq_out),
	.idle_timer_enable_out(idle_timer_enable_out));

/* File: dv/lsdu_bus_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side: master node on a wired-AND line with pull-up
// ----------------------------------------------------------------
module lsdu_bus_model (
	input wire clk_in,
	input wire txd_in,
	output wire rxd_out
);
	logic drive = 1'b1;
	logic phy_off = 1'b0;
	// Low wins; a shut-off transceiver no longer passes our own low.
	assign rxd_out = drive & (txd_in | phy_off);
	// Master sends start, eight data bits LSB first, then the stop given.
	task automatic send_frame(input logic [7:0] b, input logic stop,
		input int baud);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			drive <= f[i];
			repeat (baud) @(posedge clk_in);
		end
		drive <= 1'b1;
	endtask
	// Catch one byte of the unit at bit middles; ok drops on a hang.
	task automatic catch_byte(input int baud, output logic [7:0] b,
		output bit ok);
		int n;
		n = 0;
		while (rxd_out !== 1'b0 && n < 100 * baud) begin
			@(negedge clk_in);
			n++;
		end
		ok = n < 100 * baud;
		repeat (baud / 2) @(negedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (baud) @(negedge clk_in);
			b[i] = rxd_out;
		end
		repeat (baud / 2 + 1) @(negedge clk_in);
	endtask
endmodule

/* File: dv/test_lin_slave_data_unit.sv */
`timescale 1ns/1ps
`include "lsdu_defs.vh"
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module test_lin_slave_data_unit;
	localparam int BAUD = 16;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic sync = 1'b0;
	logic tmo = 1'b0;
	wire [7:0] rdata;
	wire rxd;
	wire txd;
	wire tmr_en;
	wire irq;
	int mismatches = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h0001299c;
	logic [7:0] exp_q[$];
	logic [7:0] d, b, t0, t1;
	bit ok;
	// Clock of 8 ns period.
	always #4 clk = ~clk;
	lsdu_top u_dut (.ref_clk_in(clk), .resetn_in(resetn),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata), .sync_strobe_in(sync),
		.measured_baud_in(16'h0010), .idle_timeout_in(tmo), .rxd_in(rxd),
		.txd_out(txd), .idle_timer_enable_out(tmr_en), .irq_out(irq));
	lsdu_bus_model u_bus (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		// A write right after a write lets one edge pass first.
		if (wr_s === 1'b1) begin
			@(posedge clk);
		end
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		v = rdata;
		@(posedge clk);
	endtask
	task automatic pulse(input int k);
		sync <= 1'b1;
		@(posedge clk);
		sync <= 1'b0;
	endtask
	task automatic chk8(input string n, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		chk8(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#600000;
		mismatches++;
		report_and_stop();
	end
	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(`LSDU_OFF_CFG, d);
		chk8("cfg reset", 8'h00, d);
		chk1("timer enable", 1'b0, tmr_en);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat reset", 8'h08, d);
		rd(8'h40, d);
		chk8("unmapped", 8'h00, d);
		wr(`LSDU_OFF_IRQEN, 8'h01);
		pulse(0);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat sync", 8'h09, d);
		chk1("irq", 1'b1, irq);
		// The baud low register is only read, never written.
		rd(`LSDU_OFF_BAUDLO, d);
		chk8("baud low", 8'h10, d);
		wr(`LSDU_OFF_STAT, 8'h01);
		wr(`LSDU_OFF_IRQEN, 8'h00);
		repeat (2) @(posedge clk);
		chk1("irq masked", 1'b0, irq);
		// Two bytes back to back; the second finds the buffer full.
		t0 = rnd8();
		t1 = rnd8();
		exp_q.push_back(t0);
		u_bus.send_frame(t0, 1'b1, BAUD);
		u_bus.send_frame(t1, 1'b1, BAUD);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat overrun", 8'h0e, d);
		rd(`LSDU_OFF_DATA, d);
		chk8("rx byte", exp_q.pop_front(), d);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat cleared", 8'h08, d);
		u_bus.send_frame(rnd8(), 1'b0, BAUD);
		rd(`LSDU_OFF_CFG, d);
		chk8("cfg low stop", 8'h00, d);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat low stop", 8'h08, d);
		pulse(0);
		rd(`LSDU_OFF_CFG, d);
		chk8("cfg resync", 8'h08, d);
		wr(`LSDU_OFF_STAT, 8'h01);
		wr(`LSDU_OFF_CFG, 8'h01);
		rd(`LSDU_OFF_CFG, d);
		chk8("cfg halt", 8'h00, d);
		u_bus.send_frame(rnd8(), 1'b1, BAUD);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat halted", 8'h08, d);
		// Sync strobe in mid byte; no falling edge follows it.
		pulse(0);
		wr(`LSDU_OFF_STAT, 8'h01);
		fork
			u_bus.send_frame(8'hff, 1'b1, BAUD);
			begin
				repeat (5 * BAUD) @(posedge clk);
				pulse(0);
			end
		join
		rd(`LSDU_OFF_STAT, d);
		chk8("stat discard", 8'h09, d);
		wr(`LSDU_OFF_CFG, 8'h01);
		wr(`LSDU_OFF_CFG, 8'h06);
		pulse(0);
		rd(`LSDU_OFF_CFG, d);
		chk8("cfg hard off", 8'h06, d);
		chk1("timer enable", 1'b1, tmr_en);
		tmo <= 1'b1;
		@(posedge clk);
		tmo <= 1'b0;
		rd(`LSDU_OFF_STAT, d);
		chk8("stat idle", 8'h89, d);
		wr(`LSDU_OFF_STAT, 8'h81);
		wr(`LSDU_OFF_CFG, 8'h00);
		// Two bytes out, a third write collides.
		pulse(0);
		wr(`LSDU_OFF_STAT, 8'h01);
		t0 = rnd8();
		t1 = rnd8();
		wr(`LSDU_OFF_DATA, t0);
		rd(`LSDU_OFF_CFG, d);
		chk8("cfg tx", 8'h20, d);
		wr(`LSDU_OFF_DATA, t1);
		wr(`LSDU_OFF_DATA, 8'h5a);
		u_bus.catch_byte(BAUD, b, ok);
		chk8("tx byte 0", t0, b);
		chk1("tx start 0", 1'b1, ok);
		@(posedge clk);
		u_bus.catch_byte(BAUD, b, ok);
		chk8("tx byte 1", t1, b);
		chk1("tx start 1", 1'b1, ok);
		repeat (BAUD) @(posedge clk);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat collision", 8'h18, d);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat read clr", 8'h08, d);
		rd(`LSDU_OFF_CFG, d);
		chk8("cfg tx done", 8'h00, d);
		// Transceiver shut off: our low never shows on the line.
		u_bus.phy_off <= 1'b1;
		wr(`LSDU_OFF_DATA, rnd8());
		repeat (3 * BAUD) @(posedge clk);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat shutoff", 8'h48, d);
		wr(`LSDU_OFF_STAT, 8'h40);
		u_bus.phy_off <= 1'b0;
		// Master pulls the line low in the middle of a high data bit.
		wr(`LSDU_OFF_DATA, 8'hff);
		repeat (2 * BAUD + 4) @(posedge clk);
		u_bus.drive <= 1'b0;
		repeat (BAUD - 6) @(posedge clk);
		u_bus.drive <= 1'b1;
		repeat (BAUD) @(posedge clk);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat conflict", 8'h28, d);
		wr(`LSDU_OFF_STAT, 8'h20);
		wr(`LSDU_OFF_DATA, 8'h55);
		repeat (3) @(posedge clk);
		pulse(0);
		rd(`LSDU_OFF_CFG, d);
		chk8("cfg sync in tx", 8'h08, d);
		rd(`LSDU_OFF_STAT, d);
		chk8("stat sync in tx", 8'h09, d);
		report_and_stop();
	end
endmodule
